// ### common/ssf_pkg.sv
/*
 * ssf_pkg: register offsets, bit positions, reset values and timing counts
 * for the system status flag bank. Assumes a 40 MHz hclk domain.
 */
//  Behaviour
//  - diagnosis error sets diag flag; it stays set after fault clears
//  - falling edge of error-detect, non-stop error, clears both diag flags
//  - self-diagnosis error sets self-diag flag; it stays set
//  - battery under 2.5 V sets sticky low latch
//  - live low flag follows battery under 2.5 V
//  - supply dip up to 20 ms (or 10 ms) sets flag; power cycle clears
//  - battery under 2.7 V sets sticky warning latch
//  - live warning flag follows battery under 2.7 V
//  - fuse flag is OR of all output module fuse indications
//  - time-data check error sets flag; clean check clears it
//  - per CPU 1..4 ready flag set when it can work with peers
//  - per CPU 1..3 resetting flag follows that CPU's reset
//  - removed CPU module counts as resetting
//  - CPU 1 resetting forces all other CPUs into reset
//  - CPU 2 or 3 reset puts the rest into multi-CPU-down, code 7000
//  - flags change only at their defined update moments
package ssf_pkg;
	localparam logic [7:0]  OFS_FLAGS    = 8'h00;
	localparam logic [7:0]  OFS_IRQ_STAT = 8'h04;
	localparam logic [7:0]  OFS_IRQ_MASK = 8'h08;
	localparam logic [7:0]  OFS_CTRL     = 8'h0C;
	localparam logic [7:0]  OFS_ERR_CODE = 8'h10;
	localparam int          B_DIAG       = 0;
	localparam int          B_SELF       = 1;
	localparam int          B_BLOW_L     = 2;
	localparam int          B_BLOW       = 3;
	localparam int          B_PWR        = 4;
	localparam int          B_BWARN_L    = 5;
	localparam int          B_BWARN      = 6;
	localparam int          B_FUSE       = 7;
	localparam int          B_TIME       = 8;
	localparam int          B_RDY0       = 9;
	localparam int          B_RST0       = 13;
	localparam int          B_MDOWN      = 16;
	localparam int          NFLAG        = 17;
	localparam int          NEVT         = 6;
	localparam int          EV_DIAG      = 0;
	localparam int          EV_SELF      = 1;
	localparam int          EV_BLOW      = 2;
	localparam int          EV_PWR       = 3;
	localparam int          EV_BWARN     = 4;
	localparam int          EV_MDOWN     = 5;
	localparam int          C_DIAG_CLR   = 0;
	localparam int          C_SELF_CLR   = 1;
	localparam int          C_DIP_SHORT  = 2;
	localparam logic [2:0]  CTRL_RESET   = 3'h0;
	localparam logic [15:0] MDOWN_CODE   = 16'h1B58;
	localparam int          CLK_HZ       = 40_000_000;
	localparam int          DIP_LONG_MS  = 20;
	localparam int          DIP_SHORT_MS = 10;
	localparam int          DIP_LONG_CYC = DIP_LONG_MS * (CLK_HZ / 1000);
	localparam int          DIP_SHORT_CYC = DIP_SHORT_MS * (CLK_HZ / 1000);
endpackage : ssf_pkg

// ### core/ssf_sync.sv
/*
 * ssf_sync: two-flop synchroniser for a bus of asynchronous levels.
 * Assumes inputs are levels that stay stable for several hclk periods.
 */
`timescale 1ns/1ps
module ssf_sync #(
	parameter int W = 1
) (
	input  wire logic         hclk,
	input  wire logic         hresetn,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_reg;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			meta_reg <= '0;
			q        <= '0;
		end else begin
			meta_reg <= d;
			q        <= meta_reg;
		end
	end
endmodule : ssf_sync

// ### core/ssf_flag_bank.sv
/*
 * ssf_flag_bank: system status flag bank with AHB-Lite register slave,
 * sticky event status, mask and one level interrupt.
 * Assumes all status input pins are asynchronous levels; AHB-Lite pins are sampled on hclk, which is 40 MHz.
 */
// Decided for this implementation: the register offsets and the AHB-Lite slave port.
`timescale 1ns/1ps
module ssf_flag_bank
	import ssf_pkg::*;
#(
	parameter int DIP_LONG  = DIP_LONG_CYC,
	parameter int DIP_SHORT = DIP_SHORT_CYC
) (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic        diag_fault,
	input  wire logic        self_diag_fault,
	input  wire logic        error_detect_flag,
	input  wire logic        error_is_stop,
	input  wire logic        batt_under_2v5,
	input  wire logic        batt_under_2v7,
	input  wire logic        supply_lost,
	input  wire logic [7:0]  module_fuse_blown,
	input  wire logic        time_check_done,
	input  wire logic        time_check_bad,
	input  wire logic [3:0]  cpu_can_operate,
	input  wire logic [2:0]  cpu_reset_in,
	input  wire logic [2:0]  cpu_removed,
	output logic             diag_error_flag,
	output logic             self_diag_error_flag,
	output logic             battery_low_latched,
	output logic             battery_low_live,
	output logic             power_interrupt_detected,
	output logic             battery_warn_latched,
	output logic             battery_warn_live,
	output logic             fuse_blown_flag,
	output logic             time_data_error_flag,
	output logic [3:0]       cpu_ready_flag,
	output logic [2:0]       cpu_in_reset_flag,
	output logic             peer_reset_req,
	output logic             multi_cpu_down,
	output logic [15:0]      multi_cpu_down_code,
	output logic             irq
);
	localparam int NS = 32;

	logic [NS-1:0]   raw;
	logic [NS-1:0]   s;
	logic [NFLAG-1:0] flags;
	logic            err_det_d_reg;
	logic            supply_d_reg;
	logic [31:0]     dip_cnt_reg;
	logic [2:0]      ctrl_reg;
	logic [NEVT-1:0] stat_reg;
	logic [NEVT-1:0] mask_reg;
	logic [NEVT-1:0] ev;
	logic            ap_wr_reg;
	logic            ap_rd_reg;
	logic [7:0]      ap_addr_reg;
	logic            clear_pulse;
	logic            dip_end;
	logic [2:0]      rst_now;

	// supply sense inverted: sync reset level then reads as present
	assign raw = {5'h00, cpu_removed, cpu_reset_in, cpu_can_operate,
		module_fuse_blown, time_check_bad, time_check_done, ~supply_lost,
		batt_under_2v7, batt_under_2v5, error_is_stop, error_detect_flag,
		self_diag_fault, diag_fault};

	ssf_sync #(
		.W (NS)
	) u_sync (
		.hclk    (hclk),
		.hresetn (hresetn),
		.d       (raw),
		.q       (s)
	);

	// synced view, named for readability
	logic s_diag, s_self, s_edet, s_stop, s_b25, s_b27, s_sup;
	logic s_tdone, s_tbad;
	logic [7:0] s_fuse;
	logic [3:0] s_can;
	logic [2:0] s_rst, s_rem;
	assign s_diag  = s[0];
	assign s_self  = s[1];
	assign s_edet  = s[2];
	assign s_stop  = s[3];
	assign s_b25   = s[4];
	assign s_b27   = s[5];
	assign s_sup   = !s[6];
	assign s_tdone = s[7];
	assign s_tbad  = s[8];
	assign s_fuse  = s[16:9];
	assign s_can   = s[20:17];
	assign s_rst   = s[23:21];
	assign s_rem   = s[26:24];

	function automatic logic is_addr(input logic [7:0] a,
		input logic [7:0] ofs);
		is_addr = (a == ofs);
	endfunction : is_addr

	// error-detect falling edge, non-stop errors only
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			err_det_d_reg <= 1'b0;
		end else begin
			err_det_d_reg <= s_edet;
		end
	end
	assign clear_pulse = err_det_d_reg && !s_edet && !s_stop;

	// error-detect release clears both diag flags when software allows
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			diag_error_flag      <= 1'b0;
			self_diag_error_flag <= 1'b0;
		end else begin
			if (s_diag) begin
				diag_error_flag <= 1'b1;
			end else if (clear_pulse && ctrl_reg[C_DIAG_CLR]) begin
				diag_error_flag <= 1'b0;
			end
			if (s_self) begin
				self_diag_error_flag <= 1'b1;
			end else if (clear_pulse && ctrl_reg[C_SELF_CLR]) begin
				self_diag_error_flag <= 1'b0;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			battery_low_latched  <= 1'b0;
			battery_low_live     <= 1'b0;
			battery_warn_latched <= 1'b0;
			battery_warn_live    <= 1'b0;
		end else begin
			battery_low_live  <= s_b25;
			battery_warn_live <= s_b27;
			if (s_b25) begin
				battery_low_latched <= 1'b1;
			end
			if (s_b27) begin
				battery_warn_latched <= 1'b1;
			end
		end
	end

	// lost cycles counted in hclk; a longer loss is a real power-off
	assign dip_end = !supply_d_reg && s_sup;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			supply_d_reg <= 1'b1;
			dip_cnt_reg  <= '0;
		end else begin
			supply_d_reg <= s_sup;
			if (s_sup) begin
				dip_cnt_reg <= '0;
			end else if (dip_cnt_reg != 32'hFFFFFFFF) begin
				dip_cnt_reg <= dip_cnt_reg + 32'h1;
			end
		end
	end

	// only hresetn (power-on) clears it
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			power_interrupt_detected <= 1'b0;
		end else if (dip_end && (dip_cnt_reg < (ctrl_reg[C_DIP_SHORT]
			? 32'(DIP_SHORT) : 32'(DIP_LONG)))) begin
			power_interrupt_detected <= 1'b1;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			fuse_blown_flag      <= 1'b0;
			time_data_error_flag <= 1'b0;
		end else begin
			fuse_blown_flag <= |s_fuse;
			if (s_tdone) begin
				time_data_error_flag <= s_tbad;
			end
		end
	end

	assign rst_now = s_rst | s_rem;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cpu_ready_flag      <= '0;
			cpu_in_reset_flag   <= '0;
			peer_reset_req      <= 1'b0;
			multi_cpu_down      <= 1'b0;
			multi_cpu_down_code <= '0;
		end else begin
			cpu_ready_flag    <= s_can;
			cpu_in_reset_flag <= rst_now;
			peer_reset_req    <= rst_now[0];
			if (!rst_now[0] && (rst_now[1] || rst_now[2])) begin
				multi_cpu_down      <= 1'b1;
				multi_cpu_down_code <= MDOWN_CODE;
			end
		end
	end

	assign flags = {multi_cpu_down, cpu_in_reset_flag, cpu_ready_flag,
		time_data_error_flag, fuse_blown_flag, battery_warn_live,
		battery_warn_latched, power_interrupt_detected, battery_low_live,
		battery_low_latched, self_diag_error_flag, diag_error_flag};

	// events: rising edges of sticky flags
	logic [NEVT-1:0] evsrc, evsrc_d_reg;
	assign evsrc = {multi_cpu_down, battery_warn_latched,
		power_interrupt_detected, battery_low_latched,
		self_diag_error_flag, diag_error_flag};
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			evsrc_d_reg <= '0;
		end else begin
			evsrc_d_reg <= evsrc;
		end
	end
	assign ev = evsrc & ~evsrc_d_reg;

	// AHB-Lite address phase capture
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ap_wr_reg   <= 1'b0;
			ap_rd_reg   <= 1'b0;
			ap_addr_reg <= '0;
		end else if (hready) begin
			ap_wr_reg   <= hsel && htrans[1] && hwrite;
			ap_rd_reg   <= hsel && htrans[1] && !hwrite;
			ap_addr_reg <= haddr[7:0];
		end
	end

	// set wins over write-one-to-clear
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			stat_reg <= '0;
		end else if (ap_wr_reg && is_addr(ap_addr_reg, OFS_IRQ_STAT)) begin
			stat_reg <= (stat_reg & ~hwdata[NEVT-1:0]) | ev;
		end else begin
			stat_reg <= stat_reg | ev;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mask_reg <= '0;
			ctrl_reg <= CTRL_RESET;
		end else if (ap_wr_reg) begin
			if (is_addr(ap_addr_reg, OFS_IRQ_MASK)) begin
				mask_reg <= hwdata[NEVT-1:0];
			end
			if (is_addr(ap_addr_reg, OFS_CTRL)) begin
				ctrl_reg <= hwdata[2:0];
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= '0;
		end else if (hready && hsel && htrans[1] && !hwrite) begin
			case (haddr[7:0])
				OFS_FLAGS:    hrdata <= {15'h0, flags};
				OFS_IRQ_STAT: hrdata <= {26'h0, stat_reg};
				OFS_IRQ_MASK: hrdata <= {26'h0, mask_reg};
				OFS_CTRL:     hrdata <= {29'h0, ctrl_reg};
				OFS_ERR_CODE: hrdata <= {16'h0, multi_cpu_down_code};
				default:      hrdata <= '0;
			endcase
		end
	end

	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign irq       = |(stat_reg & mask_reg);

	property p_sticky(f, c);
		@(posedge hclk) disable iff (!hresetn) c |=> f;
	endproperty
	diag_sticky_a: assert property (p_sticky(diag_error_flag, s_diag))
		else $error("diag flag not set");
	self_sticky_a: assert property (p_sticky(self_diag_error_flag, s_self))
		else $error("self diag flag not set");
	low_latch_a: assert property (@(posedge hclk) disable iff (!hresetn)
		battery_low_latched |=> battery_low_latched)
		else $error("battery low latch dropped");
	low_live_a: assert property (@(posedge hclk) disable iff (!hresetn)
		1'b1 |=> battery_low_live == $past(s_b25))
		else $error("live low flag wrong");
	pwr_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
		power_interrupt_detected |=> power_interrupt_detected)
		else $error("power flag cleared");
	warn_live_a: assert property (@(posedge hclk) disable iff (!hresetn)
		1'b1 |=> battery_warn_live == $past(s_b27))
		else $error("live warn flag wrong");
	fuse_or_a: assert property (@(posedge hclk) disable iff (!hresetn)
		1'b1 |=> fuse_blown_flag == |$past(s_fuse))
		else $error("fuse flag wrong");
	cpu_rst_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(s_rem[1] || s_rst[1]) |=> cpu_in_reset_flag[1])
		else $error("removed cpu not resetting");
	peer_rst_a: assert property (@(posedge hclk) disable iff (!hresetn)
		cpu_in_reset_flag[0] |-> peer_reset_req)
		else $error("cpu1 reset not forwarded");
	mdown_code_a: assert property (@(posedge hclk) disable iff (!hresetn)
		multi_cpu_down |-> multi_cpu_down_code == MDOWN_CODE)
		else $error("wrong multi cpu down code");
	diag_clr_a: assert property (
		@(posedge hclk) disable iff (!hresetn)
		clear_pulse && ctrl_reg[C_DIAG_CLR] && !s_diag |=> !diag_error_flag)
		else $error("diag flag not cleared");
	time_err_a: assert property (
		@(posedge hclk) disable iff (!hresetn)
		s_tdone |=> time_data_error_flag == $past(s_tbad))
		else $error("time data flag wrong");
	cpu_ready_a: assert property (
		@(posedge hclk) disable iff (!hresetn)
		1'b1 |=> cpu_ready_flag == $past(s_can))
		else $error("cpu ready flag wrong");
	mdown_set_a: assert property (
		@(posedge hclk) disable iff (!hresetn)
		!rst_now[0] && (rst_now[1] || rst_now[2]) |=> multi_cpu_down)
		else $error("multi cpu down not set");
	stat_set_a: assert property (
		@(posedge hclk) disable iff (!hresetn)
		ev != '0 |=> (stat_reg & $past(ev)) == $past(ev))
		else $error("status event lost");
	mdown_cov_c: cover property (@(posedge hclk) disable iff (!hresetn)
		$rose(multi_cpu_down));
	diag_cov_c: cover property (@(posedge hclk) disable iff (!hresetn)
		diag_error_flag ##1 !diag_error_flag);
	pwr_cov_c: cover property (@(posedge hclk) disable iff (!hresetn)
		$rose(power_interrupt_detected));
	irq_cov_c: cover property (@(posedge hclk) disable iff (!hresetn)
		$rose(irq));
endmodule : ssf_flag_bank

// ### verification/ssf_peer_model.sv
/* ssf_peer_model: peer CPUs on the multi-CPU bus, seen as reset,
 * removal and ready levels. Assumes the bench commands each CPU. */
`timescale 1ns/1ps
module ssf_peer_model (
	input  wire logic       hclk,
	input  wire logic       hresetn,
	input  wire logic [2:0] want_reset,
	input  wire logic [2:0] want_removed,
	input  wire logic [3:0] want_ready,
	input  wire logic       peer_reset_req,
	input  wire logic       multi_cpu_down,
	output logic      [2:0] cpu_reset_in,
	output logic      [2:0] cpu_removed,
	output logic      [3:0] cpu_can_operate
);
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cpu_reset_in    <= 3'h0;
			cpu_removed     <= 3'h0;
			cpu_can_operate <= 4'h0;
		end else begin
			// cpu 1 reset drags cpus 2 and 3 down too
			cpu_reset_in <= want_reset | {{2{peer_reset_req}}, 1'b0};
			cpu_removed  <= want_removed;
			// peers in multi-cpu-down can no longer work together
			cpu_can_operate <= multi_cpu_down ? 4'h0 : want_ready;
		end
	end
endmodule : ssf_peer_model

// ### verification/ssf_flag_bank_tb_top.sv
/* ssf_flag_bank_tb_top: self-checking bench for the flag bank.
 * Assumes 3-edge input latency and a zero-wait AHB-Lite slave. */
`timescale 1ns/1ps
module ssf_flag_bank_tb_top;
	import ssf_pkg::*;
	logic        hclk, hresetn, hsel, hwrite;
	logic [31:0] haddr, hwdata, rd;
	logic [1:0]  htrans;
	logic [2:0]  hsize, want_reset, want_removed, cpu_reset_in, cpu_removed;
	logic [3:0]  want_ready, cpu_can_operate;
	logic        diag_fault, self_diag_fault, error_detect_flag, error_is_stop;
	logic        batt_under_2v5, batt_under_2v7, supply_lost;
	logic        time_check_done, time_check_bad;
	logic [7:0]  module_fuse_blown;
	logic [31:0] hrdata;
	logic        hreadyout, hresp, hready, irq;
	logic        diag_error_flag, self_diag_error_flag, battery_low_latched;
	logic        battery_low_live, power_interrupt_detected;
	logic        battery_warn_latched, battery_warn_live, fuse_blown_flag;
	logic        time_data_error_flag, peer_reset_req, multi_cpu_down;
	logic [3:0]  cpu_ready_flag;
	logic [2:0]  cpu_in_reset_flag;
	logic [15:0] multi_cpu_down_code;
	int          bad_count, checks_done;
	assign hready = hreadyout;
	always #12.5 hclk = ~hclk;
	ssf_flag_bank #(.DIP_LONG(40), .DIP_SHORT(20)) u_dut (.*);
	ssf_peer_model u_peer (.*);
	task automatic chk(input string what, input logic [31:0] exp, got);
		checks_done++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic test_done;
		$display("comparisons %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : test_done
	// inputs pass 3 flops; 6 edges leaves room for the peer model's flop
	task automatic settle;
		repeat (6) @(posedge hclk);
		@(negedge hclk);
	endtask : settle
	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= {24'h0, a};
		hwrite <= w;
		// only the watchdog ends a wait for hready
		do @(posedge hclk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge hclk); while (hready !== 1'b1);
		rd = hrdata;
		chk("hresp", 32'h0, {31'h0, hresp});
	endtask : ahb
	task automatic rdc(input string what, input logic [7:0] a,
		input logic [31:0] exp);
		ahb(1'b0, a, 32'h0);
		chk(what, exp, rd);
	endtask : rdc
	task automatic reset_dut;
		@(posedge hclk);
		hresetn <= 1'b0;
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		@(negedge hclk);
	endtask : reset_dut
	task automatic t_reset;
		rdc("flags", OFS_FLAGS, 32'h0);
		ahb(1'b1, 8'h14, 32'hFFFFFFFF);
		rdc("unmapped", 8'h14, 32'h0);
		ahb(1'b1, OFS_FLAGS, 32'hFFFFFFFF);
		rdc("flags ro", OFS_FLAGS, 32'h0);
		$display("test reset done");
	endtask : t_reset
	task automatic t_sticky;
		@(posedge hclk);
		diag_fault <= 1'b1;
		self_diag_fault <= 1'b1;
		batt_under_2v5 <= 1'b1;
		batt_under_2v7 <= 1'b1;
		settle();
		chk("low live", 32'h1, battery_low_live);
		chk("warn live", 32'h1, battery_warn_live);
		@(posedge hclk);
		diag_fault <= 1'b0;
		self_diag_fault <= 1'b0;
		batt_under_2v5 <= 1'b0;
		batt_under_2v7 <= 1'b0;
		settle();
		chk("diag", 32'h1, diag_error_flag);
		chk("self", 32'h1, self_diag_error_flag);
		chk("low latch", 32'h1, battery_low_latched);
		chk("low live", 32'h0, battery_low_live);
		chk("warn latch", 32'h1, battery_warn_latched);
		chk("warn live", 32'h0, battery_warn_live);
		rdc("flags", OFS_FLAGS, 32'h27);
		$display("test sticky done");
	endtask : t_sticky
	task automatic t_irq;
		chk("irq", 32'h0, irq);
		rdc("status", OFS_IRQ_STAT, 32'h17);
		ahb(1'b1, OFS_IRQ_MASK, 32'h1);
		@(negedge hclk);
		chk("irq", 32'h1, irq);
		ahb(1'b1, OFS_IRQ_STAT, 32'h1);
		@(negedge hclk);
		chk("irq", 32'h0, irq);
		rdc("status", OFS_IRQ_STAT, 32'h16);
		rdc("mask", OFS_IRQ_MASK, 32'h1);
		$display("test irq done");
	endtask : t_irq
	task automatic edet(input logic stop);
		@(posedge hclk);
		error_is_stop <= stop;
		error_detect_flag <= 1'b1;
		settle();
		@(posedge hclk);
		error_detect_flag <= 1'b0;
		settle();
	endtask : edet
	task automatic t_clear;
		edet(1'b0);
		chk("diag", 32'h1, diag_error_flag);
		ahb(1'b1, OFS_CTRL, 32'h3);
		edet(1'b1);
		chk("diag", 32'h1, diag_error_flag);
		edet(1'b0);
		chk("diag", 32'h0, diag_error_flag);
		chk("self", 32'h0, self_diag_error_flag);
		$display("test clear done");
	endtask : t_clear
	task automatic t_fuse_time;
		for (int i = 0; i < 8; i++) begin
			@(posedge hclk);
			module_fuse_blown <= 8'h01 << i;
			settle();
			chk("fuse", 32'h1, fuse_blown_flag);
		end
		@(posedge hclk);
		module_fuse_blown <= 8'h00;
		time_check_bad <= 1'b1;
		time_check_done <= 1'b1;
		settle();
		chk("fuse", 32'h0, fuse_blown_flag);
		chk("time", 32'h1, time_data_error_flag);
		@(posedge hclk);
		time_check_done <= 1'b0;
		time_check_bad <= 1'b0;
		settle();
		@(posedge hclk);
		time_check_done <= 1'b1;
		settle();
		chk("time", 32'h0, time_data_error_flag);
		$display("test fuse time done");
	endtask : t_fuse_time
	task automatic dip(input int n);
		@(posedge hclk);
		supply_lost <= 1'b0;
		repeat (n) @(posedge hclk);
		supply_lost <= 1'b1;
		settle();
	endtask : dip
	task automatic t_pwr;
		dip(10);
		chk("pwr", 32'h1, power_interrupt_detected);
		reset_dut();
		chk("pwr", 32'h0, power_interrupt_detected);
		dip(60);
		chk("pwr", 32'h0, power_interrupt_detected);
		ahb(1'b1, OFS_CTRL, 32'h4);
		dip(30);
		chk("pwr", 32'h0, power_interrupt_detected);
		dip(10);
		chk("pwr", 32'h1, power_interrupt_detected);
		$display("test power done");
	endtask : t_pwr
	task automatic t_cpu;
		@(posedge hclk);
		want_ready <= 4'hF;
		settle();
		chk("ready", 32'hF, cpu_ready_flag);
		@(posedge hclk);
		want_reset <= 3'b010;
		settle();
		chk("in reset", 32'h2, cpu_in_reset_flag);
		chk("mdown", 32'h1, multi_cpu_down);
		chk("code", 32'h1B58, multi_cpu_down_code);
		rdc("code reg", OFS_ERR_CODE, 32'h1B58);
		@(posedge hclk);
		want_removed <= 3'b100;
		settle();
		chk("in reset", 32'h6, cpu_in_reset_flag);
		@(posedge hclk);
		want_reset <= 3'b000;
		want_removed <= 3'b000;
		settle();
		chk("in reset", 32'h0, cpu_in_reset_flag);
		reset_dut();
		chk("mdown", 32'h0, multi_cpu_down);
		@(posedge hclk);
		want_reset <= 3'b001;
		settle();
		settle();
		chk("in reset", 32'h7, cpu_in_reset_flag);
		chk("mdown", 32'h0, multi_cpu_down);
		$display("test cpu done");
	endtask : t_cpu
	initial begin
		repeat (20000) @(posedge hclk);
		bad_count++;
		test_done();
	end
	initial begin
		{hclk, hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
		{diag_fault, self_diag_fault, error_detect_flag, error_is_stop} = '0;
		{batt_under_2v5, batt_under_2v7, time_check_done, time_check_bad} = '0;
		{want_reset, want_removed, want_ready, module_fuse_blown} = '0;
		{bad_count, checks_done} = '0;
		supply_lost = 1'b1;
		hsize = 3'h2;
		reset_dut();
		t_reset();
		t_sticky();
		t_irq();
		t_clear();
		t_fuse_time();
		t_pwr();
		t_cpu();
		test_done();
	end
endmodule : ssf_flag_bank_tb_top
